// ### hdl/ahb_reg_slave.sv
`timescale 1ns/100ps
`default_nettype none
module ahb_reg_slave (
    input wire logic clock,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    reg_access_if.bus regs
);
    import irq_bank_pkg::*;

    slave_state_type s;
    slave_state_type next_s;
    logic accept;

    assign accept = hsel && htrans[1] && hready;

    // word-size writes commit at the end of their data phase; other sizes are dropped; reads wait one cycle
    // so a read right behind a write sees the written value
    always_comb begin
        next_s = s;
        next_s.wr_pend = accept && hwrite && (hsize == HSIZE_WORD);
        if (accept && hwrite) begin
            next_s.wr_addr = haddr;
        end
        if (s.rd_wait) begin
            next_s.rd_wait = 1'b0;
            next_s.hrdata = regs.rd_data;
        end else if (accept && !hwrite) begin
            next_s.rd_wait = 1'b1;
            next_s.rd_addr = haddr;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign regs.rd_addr = s.rd_addr;
    assign regs.wr_en = s.wr_pend;
    assign regs.wr_addr = s.wr_addr;
    assign regs.wr_data = hwdata;
    assign hreadyout = !s.rd_wait;
    assign hresp = HRESP_OKAY;
    assign hrdata = s.hrdata;

endmodule
`default_nettype wire

// ### hdl/interrupt_request_latch_bank0.sv
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module interrupt_request_latch_bank0 (
    input wire logic clock,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic pulse_timer_request,
    input wire logic converter_request,
    input wire logic comparator_request,
    input wire logic timer_zero_request,
    input wire logic serial0_receive_request,
    input wire logic serial0_transmit_request,
    input wire logic serial_periph_request,
    input wire logic first_fault_pin,
    input wire logic second_fault_pin,
    input wire logic comparator_output,
    input wire logic global_enable_set,
    input wire logic global_enable_clear,
    input wire logic vector_ack,
    input wire logic [2:0] vector_ack_source,
    output logic vector_request,
    output logic [2:0] vector_source,
    output logic global_interrupt_enable,
    output logic [7:0] pending_request_bank0,
    output logic irq
);
    import irq_bank_pkg::*;

    localparam bank_state_type BANK_RESET = '{
        pending: PENDING_RESET,
        enable: ENABLE_RESET,
        fault_enable: FAULT_ENABLE_RESET,
        status: STATUS_RESET,
        mask: MASK_RESET,
        sync1: 3'h0,
        sync2: 3'h0,
        prev: 3'h0
    };

    bank_state_type s;
    bank_state_type next_s;

    reg_access_if regs_bus ();

    logic [2:0] fault_edge;
    logic fault_request;
    logic [7:0] hw_request;
    logic [7:0] ack_bit;
    logic [3:0] wr_sel;
    logic [3:0] rd_sel;
    logic [7:0] wr_byte;

    function automatic logic [3:0] reg_select(input logic [31:0] addr);
        reg_select = 4'h0;
        reg_select[SEL_PENDING] = (addr == PENDING_OFFSET);
        reg_select[SEL_CONTROL] = (addr == CONTROL_OFFSET);
        reg_select[SEL_STATUS] = (addr == STATUS_OFFSET);
        reg_select[SEL_MASK] = (addr == MASK_OFFSET);
    endfunction

    // bit 7 has the highest fixed priority
    function automatic logic [2:0] top_source(input logic [7:0] req);
        top_source = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (req[i]) begin
                top_source = 3'(i);
            end
        end
    endfunction

    function automatic logic [7:0] source_bit(input logic [2:0] idx);
        source_bit = 8'h01 << idx;
    endfunction

    ahb_reg_slave bus_slave (
        .clock(clock),
        .srst(srst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .regs(regs_bus.bus)
    );

    // rising edges of the synchronised fault sources, each gated
    assign fault_edge = s.sync2 & ~s.prev & s.fault_enable;
    assign fault_request = |fault_edge;

    always_comb begin
        hw_request = 8'h00;
        hw_request[PULSE_TIMER_BIT] = pulse_timer_request;
        hw_request[FAULT_BIT] = fault_request;
        hw_request[CONVERTER_BIT] = converter_request;
        hw_request[COMPARATOR_BIT] = comparator_request;
        hw_request[TIMER_ZERO_BIT] = timer_zero_request;
        hw_request[SERIAL0_RECEIVE_BIT] = serial0_receive_request;
        hw_request[SERIAL0_TRANSMIT_BIT] = serial0_transmit_request;
        hw_request[SERIAL_PERIPH_BIT] = serial_periph_request;
    end

    assign ack_bit = vector_ack ? source_bit(vector_ack_source) : 8'h00;
    assign wr_sel = regs_bus.wr_en ? reg_select(regs_bus.wr_addr) : 4'h0;
    assign rd_sel = reg_select(regs_bus.rd_addr);
    assign wr_byte = regs_bus.wr_data[7:0];

    always_comb begin
        next_s = s;
        next_s.sync1 = {comparator_output, second_fault_pin, first_fault_pin};
        next_s.sync2 = s.sync1;
        next_s.prev = s.sync2;
        // software write replaces the byte; ones raise, zeros clear unless a hardware request sets that bit in the same cycle
        if (wr_sel[SEL_PENDING]) begin
            next_s.pending = wr_byte;
        end else begin
            next_s.pending = s.pending & ~ack_bit;
        end
        next_s.pending = next_s.pending | hw_request;
        if (wr_sel[SEL_CONTROL]) begin
            next_s.enable = regs_bus.wr_data[CTRL_ENABLE_BIT];
            next_s.fault_enable = regs_bus.wr_data[CTRL_FAULT_MSB:CTRL_FAULT_LSB];
        end
        if (global_enable_set) begin
            next_s.enable = 1'b1;
        end
        // acknowledge also drops the global enable
        if (global_enable_clear || vector_ack) begin
            next_s.enable = 1'b0;
        end
        if (wr_sel[SEL_STATUS]) begin
            next_s.status = s.status & ~wr_byte;
        end
        next_s.status = next_s.status | hw_request;
        if (wr_sel[SEL_MASK]) begin
            next_s.mask = wr_byte;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s <= BANK_RESET;
        end else begin
            s <= next_s;
        end
    end

    always_comb begin
        regs_bus.rd_data = WORD_ZERO;
        case (1'b1)
            rd_sel[SEL_PENDING]: regs_bus.rd_data[7:0] = s.pending;
            rd_sel[SEL_CONTROL]: begin
                regs_bus.rd_data[CTRL_ENABLE_BIT] = s.enable;
                regs_bus.rd_data[CTRL_FAULT_MSB:CTRL_FAULT_LSB] = s.fault_enable;
            end
            rd_sel[SEL_STATUS]: regs_bus.rd_data[7:0] = s.status;
            rd_sel[SEL_MASK]: regs_bus.rd_data[7:0] = s.mask;
            default: regs_bus.rd_data = WORD_ZERO;
        endcase
    end

    assign vector_request = s.enable && (s.pending != 8'h00);
    assign vector_source = top_source(s.pending);
    assign global_interrupt_enable = s.enable;
    assign pending_request_bank0 = s.pending;
    assign irq = (s.status & s.mask) != 8'h00;

    default clocking @(posedge clock);
    endclocking
    default disable iff (srst);

    AST_HW_SET: assert property (
        hw_request != 8'h00 |=> (s.pending & $past(hw_request)) == $past(hw_request)
    ) else $error("hardware request not latched");

    AST_HELD: assert property (
        (s.pending != 8'h00) && !wr_sel[SEL_PENDING] && !vector_ack
        |=> (s.pending & $past(s.pending)) == $past(s.pending)
    ) else $error("pending bit lost without clear");

    AST_FORWARD: assert property (
        s.enable && (s.pending != 8'h00) |-> vector_request
    ) else $error("enabled pending request not forwarded");

    AST_HOLD_OFF: assert property (
        !global_interrupt_enable |-> !vector_request
    ) else $error("request forwarded while disabled");

    AST_PRIORITY: assert property (
        vector_request && pending_request_bank0[PULSE_TIMER_BIT] |-> vector_source == 3'h7
    ) else $error("pulse timer not first source");

    AST_FAULT: assert property (
        s.fault_enable[0] && $rose(s.sync2[0]) |=> pending_request_bank0[FAULT_BIT]
    ) else $error("first fault pin edge not latched");

    AST_FAULT_PIN: assert property (
        $rose(first_fault_pin) && s.fault_enable[0] && !s.sync1[0] && !s.sync2[0]
        && !wr_sel[SEL_CONTROL] |-> ##3 pending_request_bank0[FAULT_BIT]
    ) else $error("fault pin request late");

    AST_READ: assert property (
        bus_slave.s.rd_wait && rd_sel[SEL_PENDING] && hw_request == 8'h00
        && !vector_ack && !wr_sel[SEL_PENDING]
        |=> hrdata[7:0] == pending_request_bank0 && hreadyout
    ) else $error("pending read mismatch");

    AST_ACK_CLEAR: assert property (
        vector_ack && (ack_bit & hw_request) == 8'h00 && !wr_sel[SEL_PENDING]
        |=> (pending_request_bank0 & $past(ack_bit)) == 8'h00 && !global_interrupt_enable
    ) else $error("vectored source not cleared");

    AST_SW_WRITE: assert property (
        wr_sel[SEL_PENDING] && hw_request == 8'h00
        |=> pending_request_bank0 == $past(wr_byte)
    ) else $error("software write not applied");

    AST_SET_WINS: assert property (
        wr_sel[SEL_PENDING] && hw_request[TIMER_ZERO_BIT] && !wr_byte[TIMER_ZERO_BIT]
        |=> pending_request_bank0[TIMER_ZERO_BIT]
    ) else $error("request lost to software clear");

    AST_ENABLE: assert property (
        wr_sel[SEL_CONTROL] && !global_enable_set && !global_enable_clear && !vector_ack
        |=> global_interrupt_enable == $past(regs_bus.wr_data[CTRL_ENABLE_BIT])
    ) else $error("global enable write not applied");

    AST_IRQ: assert property (
        hw_request[SERIAL_PERIPH_BIT] && s.mask[SERIAL_PERIPH_BIT] && !wr_sel[SEL_MASK]
        |=> irq
    ) else $error("masked-in event did not raise irq");

    AST_SOURCE_TOP: assert property (
        vector_request |-> (pending_request_bank0 >> vector_source) == 8'h01
    ) else $error("vector source not the highest pending bit");

    AST_NO_SPURIOUS: assert property (
        !wr_sel[SEL_PENDING]
        |=> (pending_request_bank0 & ~$past(pending_request_bank0) & ~$past(hw_request)) == 8'h00
    ) else $error("pending bit set without a request");

    AST_FAULT_OFF: assert property (
        s.fault_enable == 3'h0 && !pending_request_bank0[FAULT_BIT] && !wr_sel[SEL_PENDING]
        |=> !pending_request_bank0[FAULT_BIT]
    ) else $error("fault request with all fault sources disabled");

    AST_TIMER_ZERO: assert property (
        timer_zero_request |=> pending_request_bank0[TIMER_ZERO_BIT]
    ) else $error("timer zero request not pending");

    AST_ENABLE_SET: assert property (
        global_enable_set && !global_enable_clear && !vector_ack |=> global_interrupt_enable
    ) else $error("global enable not set");

    AST_ENABLE_CLEAR: assert property (
        global_enable_clear || vector_ack |=> !global_interrupt_enable
    ) else $error("global enable not cleared");

    AST_STATUS_SET: assert property (
        hw_request != 8'h00 |=> (s.status & $past(hw_request)) == $past(hw_request)
    ) else $error("event status not set");

    AST_STATUS_CLEAR: assert property (
        wr_sel[SEL_STATUS] && hw_request == 8'h00
        |=> s.status == ($past(s.status) & ~$past(wr_byte))
    ) else $error("event status write-one-to-clear wrong");

    AST_MASK_WRITE: assert property (
        wr_sel[SEL_MASK] |=> s.mask == $past(wr_byte)
    ) else $error("event mask write not applied");

    AST_ONE_WAIT: assert property (
        !hreadyout |=> hreadyout
    ) else $error("read wait longer than one cycle");

endmodule
`default_nettype wire

// ### hdl/irq_bank_pkg.sv
package irq_bank_pkg;

    localparam logic [31:0] PENDING_OFFSET = 32'h0000_0fc0;
    localparam logic [31:0] CONTROL_OFFSET = 32'h0000_0fc4;
    localparam logic [31:0] STATUS_OFFSET = 32'h0000_0fc8;
    localparam logic [31:0] MASK_OFFSET = 32'h0000_0fcc;

    localparam int SEL_PENDING = 0;
    localparam int SEL_CONTROL = 1;
    localparam int SEL_STATUS = 2;
    localparam int SEL_MASK = 3;

    localparam int PULSE_TIMER_BIT = 7;
    localparam int FAULT_BIT = 6;
    localparam int CONVERTER_BIT = 5;
    localparam int COMPARATOR_BIT = 4;
    localparam int TIMER_ZERO_BIT = 3;
    localparam int SERIAL0_RECEIVE_BIT = 2;
    localparam int SERIAL0_TRANSMIT_BIT = 1;
    localparam int SERIAL_PERIPH_BIT = 0;

    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_FAULT_LSB = 1;
    localparam int CTRL_FAULT_MSB = 3;

    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

    localparam logic [7:0] PENDING_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [2:0] FAULT_ENABLE_RESET = 3'h0;
    localparam logic ENABLE_RESET = 1'b0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic [7:0] pending;
        logic enable;
        logic [2:0] fault_enable;
        logic [7:0] status;
        logic [7:0] mask;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [2:0] prev;
    } bank_state_type;

    typedef struct packed {
        logic wr_pend;
        logic [31:0] wr_addr;
        logic rd_wait;
        logic [31:0] rd_addr;
        logic [31:0] hrdata;
    } slave_state_type;

endpackage

// ### hdl/reg_access_if.sv
`timescale 1ns/100ps
`default_nettype none
interface reg_access_if;
    logic [31:0] rd_addr;
    logic [31:0] rd_data;
    logic wr_en;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    modport bus (output rd_addr, output wr_en, output wr_addr, output wr_data,
        input rd_data);
    modport regs (input rd_addr, input wr_en, input wr_addr, input wr_data,
        output rd_data);
endinterface
`default_nettype wire

// ### tb/core_model.sv
`timescale 1ns/100ps
`default_nettype none
module core_model (
    input wire logic clock,
    input wire logic take,
    input wire logic vector_request,
    input wire logic [2:0] vector_source,
    output logic vector_ack,
    output logic [2:0] vector_ack_source
);
    initial begin
        vector_ack = 1'b0;
        vector_ack_source = 3'h0;
    end
    // vectors only to a standing request while take is high, never on two cycles in a row; otherwise the core does nothing
    always @(posedge clock) begin
        vector_ack <= take && vector_request && !vector_ack;
        vector_ack_source <= vector_source;
    end
endmodule
`default_nettype wire

// ### tb/interrupt_request_latch_bank0_tb.sv
`timescale 1ns/100ps
`default_nettype none
module interrupt_request_latch_bank0_tb;
    import irq_bank_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = WORD_ZERO;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = WORD_ZERO;
    logic [7:0] req = 8'h00;
    logic [7:0] race = 8'h00;
    logic race_on = 1'b0;
    logic [7:0] srcs;
    logic [2:0] fp = 3'h0;
    logic gset = 1'b0;
    logic gclr = 1'b0;
    logic take = 1'b0;
    logic hreadyout, hresp, vector_ack, vector_request, gie, irq;
    logic [31:0] hrdata;
    logic [2:0] vector_ack_source, vector_source;
    logic [7:0] pend;
    int miscompares = 0;
    int checks_done = 0;

    // race requests only stand in a write's data phase
    assign srcs = req | (race_on ? race : 8'h00);

    interrupt_request_latch_bank0 dut (.clock(clock), .srst(srst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .pulse_timer_request(srcs[7]), .converter_request(srcs[5]),
        .comparator_request(srcs[4]), .timer_zero_request(srcs[3]),
        .serial0_receive_request(srcs[2]), .serial0_transmit_request(srcs[1]),
        .serial_periph_request(srcs[0]), .first_fault_pin(fp[0]),
        .second_fault_pin(fp[1]), .comparator_output(fp[2]),
        .global_enable_set(gset), .global_enable_clear(gclr),
        .vector_ack(vector_ack), .vector_ack_source(vector_ack_source),
        .vector_request(vector_request), .vector_source(vector_source),
        .global_interrupt_enable(gie), .pending_request_bank0(pend), .irq(irq));

    core_model core (.clock(clock), .take(take), .vector_request(vector_request),
        .vector_source(vector_source), .vector_ack(vector_ack),
        .vector_ack_source(vector_ack_source));

    initial begin
        forever #25 clock = ~clock;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk1(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        race_on <= 1'b1;
        do @(posedge clock); while (hreadyout !== 1'b1);
        q = hrdata;
        race_on <= 1'b0;
        chk1("hresp", HRESP_OKAY, hresp);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, WORD_ZERO, q);
        chk(n, e, q);
    endtask

    task automatic t_reset;
        rdc("pending", PENDING_OFFSET, WORD_ZERO);
        rdc("control", CONTROL_OFFSET, WORD_ZERO);
        rdc("status", STATUS_OFFSET, WORD_ZERO);
        rdc("mask", MASK_OFFSET, WORD_ZERO);
        wr(32'h0000_0f00, 32'h0000_00ff);
        rdc("unmapped", 32'h0000_0f00, WORD_ZERO);
        chk1("irq", 1'b0, irq);
        $display("test reset done");
    endtask

    task automatic t_sources;
        for (int i = 0; i < 8; i++) begin
            if (i != FAULT_BIT) begin
                req <= 8'h01 << i;
                @(posedge clock);
                req <= 8'h00;
                repeat (3) @(posedge clock);
                chk("pending", 32'h1 << i, 32'(pend));
                chk1("vector_request", 1'b0, vector_request);
                rdc("pending", PENDING_OFFSET, 32'h1 << i);
                wr(PENDING_OFFSET, WORD_ZERO);
                rdc("pending", PENDING_OFFSET, WORD_ZERO);
            end
        end
        $display("test sources done");
    endtask

    task automatic t_fault;
        fp <= 3'h7;
        repeat (5) @(posedge clock);
        rdc("pending", PENDING_OFFSET, WORD_ZERO);
        for (int j = 0; j < 3; j++) begin
            fp <= 3'h0;
            wr(CONTROL_OFFSET, 32'h2 << j);
            rdc("control", CONTROL_OFFSET, 32'h2 << j);
            fp <= 3'h1 << j;
            repeat (5) @(posedge clock);
            rdc("pending", PENDING_OFFSET, 32'h0000_0040);
            wr(PENDING_OFFSET, WORD_ZERO);
        end
        fp <= 3'h0;
        $display("test fault done");
    endtask

    task automatic t_vector;
        wr(PENDING_OFFSET, 32'h0000_0009);
        rdc("pending", PENDING_OFFSET, 32'h0000_0009);
        chk1("vector_request", 1'b0, vector_request);
        gset <= 1'b1;
        @(posedge clock);
        gset <= 1'b0;
        @(posedge clock);
        chk1("enable", 1'b1, gie);
        chk1("vector_request", 1'b1, vector_request);
        chk("vector_source", 32'h3, 32'(vector_source));
        req <= 8'h80;
        @(posedge clock);
        req <= 8'h00;
        @(posedge clock);
        chk("vector_source", 32'h7, 32'(vector_source));
        wr(PENDING_OFFSET, 32'h0000_0009);
        gclr <= 1'b1;
        @(posedge clock);
        gclr <= 1'b0;
        @(posedge clock);
        chk1("vector_request", 1'b0, vector_request);
        take <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            gset <= 1'b1;
            @(posedge clock);
            gset <= 1'b0;
            for (int n = 0; n < 20 && pend !== 8'h01 >> k; n++) @(posedge clock);
            @(posedge clock);
            chk("pending", 32'h1 >> k, 32'(pend));
            chk1("enable", 1'b0, gie);
        end
        take <= 1'b0;
        $display("test vector done");
    endtask

    task automatic t_race;
        race <= 8'h08;
        wr(PENDING_OFFSET, WORD_ZERO);
        race <= 8'h00;
        rdc("pending", PENDING_OFFSET, 32'h0000_0008);
        wr(PENDING_OFFSET, WORD_ZERO);
        $display("test race done");
    endtask

    task automatic t_irq;
        rdc("status", STATUS_OFFSET, 32'h0000_00ff);
        chk1("irq", 1'b0, irq);
        wr(MASK_OFFSET, 32'h0000_0020);
        rdc("mask", MASK_OFFSET, 32'h0000_0020);
        chk1("irq", 1'b1, irq);
        wr(STATUS_OFFSET, 32'h0000_00df);
        rdc("status", STATUS_OFFSET, 32'h0000_0020);
        chk1("irq", 1'b1, irq);
        wr(STATUS_OFFSET, 32'h0000_0020);
        rdc("status", STATUS_OFFSET, WORD_ZERO);
        chk1("irq", 1'b0, irq);
        wr(MASK_OFFSET, 32'h0000_0001);
        req <= 8'h01;
        @(posedge clock);
        req <= 8'h00;
        @(posedge clock);
        chk1("irq", 1'b1, irq);
        rdc("status", STATUS_OFFSET, 32'h0000_0001);
        $display("test irq done");
    endtask

    initial begin
        repeat (4000) @(posedge clock);
        miscompares++;
        print_verdict;
    end

    initial begin
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        t_reset;
        t_sources;
        t_fault;
        t_vector;
        t_race;
        t_irq;
        print_verdict;
    end
endmodule
`default_nettype wire
